// [rfbuf_pkg.sv]
// rfbuf_pkg.sv: constants, types and helpers of the radio frame buffer
// Notes on behaviour
// - 128-byte buffer, host port and baseband port usable at once.
// - buffer spans 0x00..0x7f, holds one frame, rx or tx.
// - host frame write beyond 128 bytes raises underrun; contents undefined.
// - access only outside sleep; in power-on only with master clock.
// - data kept until host write, new frame, sleep or reset.
// - unprotected frame arriving during host frame read overwrites, raises underrun.
// - frames received while auto-retry awaits ack are not stored.
// - receive stores payload then link quality, never the length byte.
// - frame-mode read gives the length byte before the payload.
// - random-address read never yields length or sync header.
// - with auto checksum the last two payload bytes become computed FCS.
// - frames of length byte plus one data byte are accepted.
// - host port and baseband port each keep their own address counter.
// - read during receive violates when host counter >= receive counter.
// - write during transmit violates when host counter <= transmit counter.
// - violations raise underrun only in frame mode, never in random mode.
// - underrun meaningful 64 us after receive start; earlier ones ignorable.
package rfbuf_pkg;
  localparam int unsigned BUF_DEPTH     = 128;
  localparam int unsigned ADDR_W        = 7;
  localparam logic [7:0]  CNT_RESET     = 8'h00;
  localparam logic [7:0]  FRAME_MAX     = 8'h80;
  localparam logic [7:0]  FCS_MIN_LEN   = 8'h02;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam logic [15:0] FCS_INIT      = 16'h0000;
  localparam logic [15:0] FCS_POLY      = 16'h8408;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RX_READ_NS    = 32000;
  localparam int unsigned UR_VALID_NS   = 64000;
  localparam int unsigned RX_READ_CYC   =
    (RX_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned UR_VALID_CYC  =
    (UR_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W         = 16;
  localparam logic [15:0] TMR_RESET     = 16'h0000;

  // baseband commands carried across the link
  typedef enum logic [2:0] {
    CMD_RX_START = 3'h0,
    CMD_RX_BYTE  = 3'h1,
    CMD_RX_END   = 3'h2,
    CMD_TX_START = 3'h3,
    CMD_TX_BYTE  = 3'h4,
    CMD_TX_ABORT = 3'h5
  } rfbuf_cmd_t;

  // link side handshake states
  typedef enum logic {
    LK_IDLE = 1'b0,
    LK_WAIT = 1'b1
  } rfbuf_link_t;

  // one byte of the 16-bit checksum, lsb first
  function automatic logic [15:0] rfbuf_fcs_step(input logic [15:0] c,
                                                 input logic [7:0]  d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ FCS_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : rfbuf_fcs_step
endpackage : rfbuf_pkg

// [rfbuf_sync.sv]
// rfbuf_sync.sv: two-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module rfbuf_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= '0;
      o_q    <= '0;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule : rfbuf_sync
`default_nettype wire

// [rfbuf_top.sv]
// rfbuf_top.sv: dual-port frame buffer with host and baseband ports
`timescale 1ns/100ps
`default_nettype none
module rfbuf_top
  import rfbuf_pkg::*;
#(
  parameter int unsigned P_RX_READ_CYC  = RX_READ_CYC,
  parameter int unsigned P_UR_VALID_CYC = UR_VALID_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  input  wire logic       i_clk_bb,
  input  wire logic       i_host_start,
  input  wire logic       i_host_end,
  input  wire logic       i_host_req,
  input  wire logic       i_host_we,
  input  wire logic       i_host_frame_mode,
  input  wire logic [6:0] i_host_addr,
  input  wire logic [7:0] i_host_wdata,
  output logic            o_host_ack,
  output logic      [7:0] o_host_rdata,
  output logic            o_access_ok,
  input  wire logic       i_sleep,
  input  wire logic       i_pon_state,
  input  wire logic       i_master_clock_ok,
  input  wire logic       i_rx_protect,
  input  wire logic       i_tx_auto_retry,
  input  wire logic       i_wait_ack,
  input  wire logic       i_auto_fcs,
  input  wire logic       i_irq_ack,
  output logic            o_buffer_underrun_irq,
  output logic            o_rx_read_ok,
  output logic            o_ur_valid,
  input  wire logic       i_bb_cmd_valid,
  input  wire logic [2:0] i_bb_cmd,
  input  wire logic [7:0] i_bb_cmd_data,
  output logic            o_bb_cmd_ready,
  output logic      [7:0] o_bb_tx_data,
  output logic            o_bb_tx_valid
);
  // frame store, one port per side
  logic [7:0]  mem [BUF_DEPTH];

  // baseband domain
  rfbuf_link_t link_q;
  logic [2:0]  cmd_hold_q;
  logic [7:0]  data_hold_q;
  logic        req_tgl_q;
  logic        ack_seen_q;
  logic        ack_s;

  // system domain
  logic [1:0]  sys_s;
  logic        req_s;
  logic        mclk_s;
  logic        req_seen_q;
  logic        ack_tgl_q;
  logic [7:0]  tx_rd_q;
  logic        bb_evt;
  rfbuf_cmd_t  cmd;
  logic [7:0]  host_cnt_q;
  logic        len_phase_q;
  logic        host_frame_q;
  logic        rx_active_q;
  logic        rx_store_q;
  logic [7:0]  rx_cnt_q;
  logic [7:0]  rx_len_q;
  logic        tx_active_q;
  logic [7:0]  tx_cnt_q;
  logic [7:0]  tx_len_q;
  logic [15:0] fcs_q;
  logic        valid_q;
  logic        irq_q;
  logic [TMR_W-1:0] tmr_q;
  logic        access_ok;
  logic        host_go;
  logic        frame_full;
  logic        host_wr;
  logic [6:0]  host_addr;
  logic        ovf_ur;
  logic        rx_viol;
  logic        tx_viol;
  logic        collide_ur;
  logic        drop_rx;
  logic        bb_wr;
  logic [7:0]  tx_byte;
  logic [7:0]  mem_tx;
  logic        last_tx;

  // ---------------- baseband side, link clock ----------------

  rfbuf_sync #(.W(1)) u_ack_sync (
    .i_clk    (i_clk_bb),
    .i_resetn (i_resetn),
    .i_d      (ack_tgl_q),
    .o_q      (ack_s)
  );

  assign o_bb_cmd_ready = (link_q == LK_IDLE);

  // one command in flight; hold regs stay stable until the ack returns
  always_ff @(posedge i_clk_bb or negedge i_resetn) begin
    if (!i_resetn) begin
      link_q      <= LK_IDLE;
      cmd_hold_q  <= 3'h0;
      data_hold_q <= 8'h00;
      req_tgl_q   <= 1'b0;
      ack_seen_q  <= 1'b0;
    end else begin
      case (link_q)
        LK_IDLE: begin
          if (i_bb_cmd_valid) begin
            cmd_hold_q  <= i_bb_cmd;
            data_hold_q <= i_bb_cmd_data;
            req_tgl_q   <= ~req_tgl_q;
            link_q      <= LK_WAIT;
          end
        end
        LK_WAIT: begin
          if (ack_s != ack_seen_q) begin
            ack_seen_q <= ack_s;
            link_q     <= LK_IDLE;
          end
        end
        default: link_q <= LK_IDLE;
      endcase
    end
  end

  // transmit byte handed back once the ack has crossed
  always_ff @(posedge i_clk_bb or negedge i_resetn) begin
    if (!i_resetn) begin
      o_bb_tx_data  <= DATA_RESET;
      o_bb_tx_valid <= 1'b0;
    end else begin
      o_bb_tx_valid <= 1'b0;
      if (link_q == LK_WAIT && ack_s != ack_seen_q &&
          cmd_hold_q == CMD_TX_BYTE) begin
        o_bb_tx_data  <= tx_rd_q;
        o_bb_tx_valid <= 1'b1;
      end
    end
  end

  // ---------------- system side ----------------

  rfbuf_sync #(.W(2)) u_sys_sync (
    .i_clk    (i_clk_sys),
    .i_resetn (i_resetn),
    .i_d      ({req_tgl_q, i_master_clock_ok}),
    .o_q      (sys_s)
  );
  assign req_s  = sys_s[1];
  assign mclk_s = sys_s[0];

  // toggle edge marks a new baseband command
  assign bb_evt = (req_s != req_seen_q);
  assign cmd    = rfbuf_cmd_t'(cmd_hold_q);

  // no access while the regulator is down
  assign access_ok  = !i_sleep && (!i_pon_state || mclk_s);
  assign o_access_ok = access_ok;
  assign host_go    = i_host_req && access_ok;
  assign frame_full = (host_cnt_q >= FRAME_MAX);
  assign host_addr  = i_host_frame_mode ? host_cnt_q[6:0]
                                        : i_host_addr;
  assign host_wr    = host_go && i_host_we &&
                      !(i_host_frame_mode && frame_full);
  assign ovf_ur     = host_go && i_host_we &&
                      i_host_frame_mode && frame_full;

  // overlap checks exist in frame mode only
  assign rx_viol = host_go && !i_host_we && i_host_frame_mode &&
                   !len_phase_q && rx_active_q &&
                   (host_cnt_q >= rx_cnt_q);
  assign tx_viol = host_go && i_host_we && i_host_frame_mode &&
                   tx_active_q && (host_cnt_q <= tx_cnt_q);

  // awaiting an ack, or protected during a host frame session: keep old frame
  assign drop_rx = (i_tx_auto_retry && i_wait_ack) ||
                   (i_rx_protect && host_frame_q);
  assign collide_ur = bb_evt && cmd == CMD_RX_START &&
                      host_frame_q && !drop_rx;

  // payload and trailing link quality, bounded by buffer end
  assign bb_wr = bb_evt && rx_active_q && rx_store_q &&
                 (cmd == CMD_RX_BYTE || cmd == CMD_RX_END) &&
                 (rx_cnt_q < FRAME_MAX);

  // checksum takes the last two payload positions
  assign mem_tx  = mem[tx_cnt_q[6:0]];
  always_comb begin
    tx_byte = mem_tx;
    if (i_auto_fcs && tx_cnt_q != CNT_RESET &&
        tx_len_q >= FCS_MIN_LEN) begin
      if (tx_cnt_q == tx_len_q - 8'h01) begin
        tx_byte = fcs_q[7:0];
      end else if (tx_cnt_q == tx_len_q) begin
        tx_byte = fcs_q[15:8];
      end
    end
  end
  // a length of one still sends its single data byte
  assign last_tx = (tx_cnt_q != CNT_RESET) &&
                   (tx_cnt_q >= tx_len_q);

  // store; baseband wins a same-address clash
  always_ff @(posedge i_clk_sys) begin
    if (host_wr) begin
      mem[host_addr] <= i_host_wdata;
    end
    if (bb_wr) begin
      mem[rx_cnt_q[6:0]] <= data_hold_q;
    end
  end

  // link acknowledge and transmit byte fetch
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      req_seen_q <= 1'b0;
      ack_tgl_q  <= 1'b0;
      tx_rd_q    <= DATA_RESET;
    end else if (bb_evt) begin
      req_seen_q <= req_s;
      ack_tgl_q  <= ~ack_tgl_q;
      if (cmd == CMD_TX_BYTE) begin
        tx_rd_q <= valid_q ? tx_byte : DATA_RESET;
      end
    end
  end

  // receive counter and stored length
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_active_q <= 1'b0;
      rx_store_q  <= 1'b0;
      rx_cnt_q    <= CNT_RESET;
      rx_len_q    <= CNT_RESET;
    end else if (i_sleep) begin
      rx_active_q <= 1'b0;
      rx_cnt_q    <= CNT_RESET;
      rx_len_q    <= CNT_RESET;
    end else if (bb_evt) begin
      case (cmd)
        CMD_RX_START: begin
          rx_active_q <= 1'b1;
          rx_store_q  <= !drop_rx;
          rx_cnt_q    <= CNT_RESET;
        end
        CMD_RX_BYTE: begin
          if (bb_wr) begin
            rx_cnt_q <= rx_cnt_q + 8'h01;
          end
        end
        CMD_RX_END: begin
          rx_active_q <= 1'b0;
          if (rx_store_q) begin
            rx_len_q <= rx_cnt_q;
          end
        end
        default: ;
      endcase
    end
  end

  // transmit counter, length capture and running checksum
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_active_q <= 1'b0;
      tx_cnt_q    <= CNT_RESET;
      tx_len_q    <= CNT_RESET;
      fcs_q       <= FCS_INIT;
    end else if (i_sleep) begin
      tx_active_q <= 1'b0;
      tx_cnt_q    <= CNT_RESET;
    end else if (bb_evt) begin
      case (cmd)
        CMD_TX_START: begin
          tx_active_q <= 1'b1;
          tx_cnt_q    <= CNT_RESET;
          fcs_q       <= FCS_INIT;
        end
        CMD_TX_BYTE: begin
          if (tx_cnt_q == CNT_RESET) begin
            tx_len_q <= {1'b0, mem_tx[6:0]};
          end else if (tx_cnt_q + 8'h02 <= tx_len_q) begin
            fcs_q <= rfbuf_fcs_step(fcs_q, mem_tx);
          end
          if (last_tx || tx_cnt_q == FRAME_MAX - 8'h01) begin
            tx_active_q <= 1'b0;
          end
          tx_cnt_q <= tx_cnt_q + 8'h01;
        end
        CMD_TX_ABORT: tx_active_q <= 1'b0;
        default: ;
      endcase
    end
  end

  // content kept until host write, new frame, sleep or reset
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      valid_q <= 1'b0;
    end else if (i_sleep) begin
      valid_q <= 1'b0;
    end else if (host_wr || bb_wr) begin
      valid_q <= 1'b1;
    end
  end

  // host frame session: counter restarts, length byte leads reads
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      host_cnt_q   <= CNT_RESET;
      len_phase_q  <= 1'b0;
      host_frame_q <= 1'b0;
    end else if (i_sleep || i_host_end) begin
      host_frame_q <= 1'b0;
      len_phase_q  <= 1'b0;
    end else if (i_host_start) begin
      host_cnt_q   <= CNT_RESET;
      len_phase_q  <= i_host_frame_mode && !i_host_we;
      host_frame_q <= i_host_frame_mode;
    end else if (host_go && i_host_frame_mode) begin
      if (len_phase_q) begin
        len_phase_q <= 1'b0;
      end else if (!frame_full) begin
        host_cnt_q <= host_cnt_q + 8'h01;
      end
    end
  end

  // read data: length first in frame mode, raw bytes in random mode
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_host_ack   <= 1'b0;
      o_host_rdata <= DATA_RESET;
    end else begin
      o_host_ack <= host_go;
      if (host_go && !i_host_we) begin
        if (i_host_frame_mode && len_phase_q) begin
          o_host_rdata <= rx_len_q;
        end else if (!valid_q || (i_host_frame_mode && frame_full)) begin
          o_host_rdata <= DATA_RESET;
        end else begin
          o_host_rdata <= mem[host_addr];
        end
      end
    end
  end

  // time since receive start, for read and underrun validity
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      tmr_q <= TMR_RESET;
    end else if (bb_evt && cmd == CMD_RX_START) begin
      tmr_q <= TMR_RESET;
    end else if (tmr_q < TMR_W'(P_UR_VALID_CYC)) begin
      tmr_q <= tmr_q + 16'h0001;
    end
  end
  assign o_rx_read_ok = (tmr_q >= TMR_W'(P_RX_READ_CYC));
  assign o_ur_valid   = (tmr_q >= TMR_W'(P_UR_VALID_CYC));

  // pending underrun: a new event beats a same-cycle acknowledge
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (irq_q && !i_irq_ack) ||
               ovf_ur || collide_ur || rx_viol || tx_viol;
    end
  end
  assign o_buffer_underrun_irq = irq_q;
endmodule : rfbuf_top
`default_nettype wire

// [rfbuf_top_sva.sv]
// rfbuf_top_sva.sv: port-level checker of the frame buffer
`timescale 1ns/100ps
`default_nettype none
module rfbuf_top_sva (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_clk_bb,
  input wire logic i_host_req,
  input wire logic i_sleep,
  input wire logic i_pon_state,
  input wire logic i_irq_ack,
  input wire logic o_host_ack,
  input wire logic o_access_ok,
  input wire logic o_buffer_underrun_irq,
  input wire logic o_rx_read_ok,
  input wire logic o_ur_valid,
  input wire logic i_bb_cmd_valid,
  input wire logic o_bb_cmd_ready,
  input wire logic o_bb_tx_valid
);
  // host port answers exactly one cycle after an accepted request
  a_ack_one_cycle: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    i_host_req && o_access_ok |=> o_host_ack) else $error("host ack missing");
  a_no_ack_refused: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    !(i_host_req && o_access_ok) |=> !o_host_ack) else $error("stray host ack");
  a_sleep_blocks: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    i_sleep |-> !o_access_ok) else $error("access open in sleep");
  a_awake_open: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    !i_sleep && !i_pon_state |-> o_access_ok) else $error("access shut");
  // pending underrun may only drop after an acknowledge
  a_irq_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_buffer_underrun_irq && !i_irq_ack |=> o_buffer_underrun_irq)
    else $error("underrun lost");
  a_ur_after_rd: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_ur_valid |-> o_rx_read_ok) else $error("underrun window early");
  // link handshake: a taken command closes the link, which reopens in time
  a_bb_take_close: assert property (@(posedge i_clk_bb) disable iff (!i_resetn)
    i_bb_cmd_valid && o_bb_cmd_ready |=> !o_bb_cmd_ready) else $error("link open");
  a_bb_reopen: assert property (@(posedge i_clk_bb) disable iff (!i_resetn)
    $fell(o_bb_cmd_ready) |-> ##[1:20] o_bb_cmd_ready) else $error("link stuck");
  a_tx_one_pulse: assert property (@(posedge i_clk_bb) disable iff (!i_resetn)
    o_bb_tx_valid |=> !o_bb_tx_valid) else $error("tx valid too long");
  a_tx_with_ready: assert property (@(posedge i_clk_bb) disable iff (!i_resetn)
    o_bb_tx_valid |-> o_bb_cmd_ready) else $error("tx byte without ready");
  c_host_ack: cover property (@(posedge i_clk_sys) o_host_ack);
  c_irq_set: cover property (@(posedge i_clk_sys) $rose(o_buffer_underrun_irq));
  c_tx_byte: cover property (@(posedge i_clk_bb) o_bb_tx_valid);
endmodule : rfbuf_top_sva
bind rfbuf_top rfbuf_top_sva i_sva (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
  .i_clk_bb(i_clk_bb), .i_host_req(i_host_req), .i_sleep(i_sleep),
  .i_pon_state(i_pon_state), .i_irq_ack(i_irq_ack), .o_host_ack(o_host_ack),
  .o_access_ok(o_access_ok), .o_buffer_underrun_irq(o_buffer_underrun_irq),
  .o_rx_read_ok(o_rx_read_ok), .o_ur_valid(o_ur_valid),
  .i_bb_cmd_valid(i_bb_cmd_valid), .o_bb_cmd_ready(o_bb_cmd_ready),
  .o_bb_tx_valid(o_bb_tx_valid));
`default_nettype wire

// [rfbuf_bb_model.sv]
// rfbuf_bb_model.sv: baseband side model driving the link commands
`timescale 1ns/100ps
`default_nettype none
module rfbuf_bb_model (
  input  wire logic       i_clk_bb,
  input  wire logic       i_ready,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_valid,
  output logic            o_valid,
  output logic      [2:0] o_cmd,
  output logic      [7:0] o_data
);
  logic [7:0] tx_q;
  initial begin
    o_valid = 1'b0;
    o_cmd   = 3'h7;
    o_data  = 8'h00;
    tx_q    = 8'h00;
  end
  // command held from a falling edge until a rising edge finds ready
  task automatic send(input logic [2:0] c, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge i_clk_bb);
    o_valid = 1'b1;
    o_cmd   = c;
    o_data  = d;
    while (!i_ready && n < 50) begin
      @(negedge i_clk_bb);
      n++;
    end
    @(negedge i_clk_bb);
    // released lines show the inverse so a stale value never passes
    o_valid = 1'b0;
    o_cmd   = ~c;
    o_data  = ~d;
    n = 0;
    while (!i_ready && n < 50) begin
      @(negedge i_clk_bb);
      n++;
    end
    if (i_tx_valid) begin
      tx_q = i_tx_data;
    end
  endtask : send
endmodule : rfbuf_bb_model
`default_nettype wire

// [tb_radio_frame_buffer.sv]
// tb_radio_frame_buffer.sv: self-checking bench of the frame buffer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED %0t: got %h expected %h", $time, a, b); end end
module tb_radio_frame_buffer;
  import rfbuf_pkg::*;
  logic clk, rstn, clk_bb, st, en, req, we, fm, ack, aok, slp, pon, mok;
  logic prot, rtry, wack, afcs, iack, irq, rok, urv, bv, brdy, btv;
  logic [6:0] addr;
  logic [7:0] wd, rd, bd, btd;
  logic [2:0] bc;
  int num_errors, n_compared;
  rfbuf_top #(.P_RX_READ_CYC(32), .P_UR_VALID_CYC(64)) i_dut (
    .i_clk_sys(clk), .i_resetn(rstn), .i_clk_bb(clk_bb), .i_host_start(st),
    .i_host_end(en), .i_host_req(req), .i_host_we(we), .i_host_frame_mode(fm),
    .i_host_addr(addr), .i_host_wdata(wd), .o_host_ack(ack),
    .o_host_rdata(rd), .o_access_ok(aok), .i_sleep(slp), .i_pon_state(pon),
    .i_master_clock_ok(mok), .i_rx_protect(prot), .i_tx_auto_retry(rtry),
    .i_wait_ack(wack), .i_auto_fcs(afcs), .i_irq_ack(iack),
    .o_buffer_underrun_irq(irq), .o_rx_read_ok(rok), .o_ur_valid(urv),
    .i_bb_cmd_valid(bv), .i_bb_cmd(bc), .i_bb_cmd_data(bd),
    .o_bb_cmd_ready(brdy), .o_bb_tx_data(btd), .o_bb_tx_valid(btv));
  rfbuf_bb_model i_bb (.i_clk_bb(clk_bb), .i_ready(brdy), .i_tx_data(btd),
    .i_tx_valid(btv), .o_valid(bv), .o_cmd(bc), .o_data(bd));
  // clocks: link clock unrelated in phase to the system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    clk_bb = 1'b0;
    #7;
    forever #24 clk_bb = ~clk_bb;
  end
  task automatic close_out();
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  // host session helpers, all entered at a falling edge
  task automatic h_start(input logic m);
    @(negedge clk);
    fm = m;
    st = 1'b1;
    @(negedge clk);
    st = 1'b0;
  endtask : h_start
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d,
                     input logic e, output logic [7:0] q);
    req  = 1'b1;
    we   = w;
    addr = a;
    wd   = d;
    @(negedge clk);
    q = rd;
    `CHK(ack, e)
  endtask : acc
  task automatic h_end();
    req = 1'b0;
    en  = 1'b1;
    @(negedge clk);
    en = 1'b0;
  endtask : h_end
  task automatic peek(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    h_start(1'b0);
    acc(1'b0, a, 8'h00, 1'b1, q);
    h_end();
    `CHK(q, e)
  endtask : peek
  task automatic irq_clear();
    iack = 1'b1;
    @(negedge clk);
    iack = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
  endtask : irq_clear
  // receive three bytes plus link quality, read back in both modes
  task automatic t_rx();
    logic [7:0] q;
    logic [7:0] e [5];
    int n;
    e = '{8'h03, 8'ha1, 8'ha2, 8'ha3, 8'h6c};
    n = 0;
    i_bb.send(3'h0, 8'h00);
    while (!rok && n < 100) begin
      @(negedge clk);
      n++;
    end
    `CHK(rok, 1'b1)
    `CHK(urv, 1'b0)
    repeat (32) @(negedge clk);
    `CHK(urv, 1'b1)
    for (int i = 1; i < 4; i++) i_bb.send(3'h1, e[i]);
    i_bb.send(3'h2, e[4]);
    h_start(1'b1);
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, 7'h00, 8'h00, 1'b1, q);
      `CHK(q, e[i])
    end
    h_end();
    peek(7'h00, 8'ha1);
  endtask : t_rx
  // frame of two data bytes written by the host, then fetched by the transmitter
  task automatic t_tx();
    logic [7:0] q;
    logic [7:0] e [3];
    e = '{8'h02, 8'h5a, 8'hc3};
    // write direction must stand at session start, else length-first arms
    we = 1'b1;
    h_start(1'b1);
    for (int i = 0; i < 3; i++) acc(1'b1, 7'h00, e[i], 1'b1, q);
    h_end();
    i_bb.send(3'h3, 8'h00);
    for (int i = 0; i < 3; i++) begin
      i_bb.send(3'h4, 8'h00);
      `CHK(i_bb.tx_q, e[i])
    end
  endtask : t_tx
  // auto checksum replaces the two bytes after the single data byte
  task automatic t_fcs();
    logic [7:0]  q;
    logic [7:0]  e [4];
    logic [15:0] c;
    e = '{8'h03, 8'h5a, 8'h00, 8'h00};
    c = FCS_INIT;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ e[1][i]) ? ((c >> 1) ^ FCS_POLY) : (c >> 1);
    end
    we = 1'b1;
    h_start(1'b1);
    for (int i = 0; i < 4; i++) acc(1'b1, 7'h00, e[i], 1'b1, q);
    h_end();
    afcs = 1'b1;
    e[2] = c[7:0];
    e[3] = c[15:8];
    i_bb.send(3'h3, 8'h00);
    for (int i = 0; i < 4; i++) begin
      i_bb.send(3'h4, 8'h00);
      `CHK(i_bb.tx_q, e[i])
    end
    @(negedge clk);
    afcs = 1'b0;
  endtask : t_fcs
  // frame arriving while waiting for an acknowledge leaves tx data intact
  task automatic t_retry();
    @(negedge clk);
    rtry = 1'b1;
    wack = 1'b1;
    i_bb.send(3'h0, 8'h00);
    i_bb.send(3'h1, 8'hee);
    i_bb.send(3'h2, 8'h11);
    @(negedge clk);
    rtry = 1'b0;
    wack = 1'b0;
    peek(7'h01, 8'h5a);
  endtask : t_retry
  // overwrite during a frame session raises a sticky underrun
  task automatic t_overwrite();
    h_start(1'b0);
    i_bb.send(3'h0, 8'h00);
    i_bb.send(3'h2, 8'h00);
    h_end();
    `CHK(irq, 1'b0)
    h_start(1'b1);
    i_bb.send(3'h0, 8'h00);
    @(negedge clk);
    `CHK(irq, 1'b1)
    repeat (5) @(negedge clk);
    `CHK(irq, 1'b1)
    h_end();
    i_bb.send(3'h2, 8'h00);
    // back onto the system clock's falling edge before driving
    @(negedge clk);
    irq_clear();
  endtask : t_overwrite
  // a host frame one byte past the buffer end
  task automatic t_overflow();
    logic [7:0] q;
    we = 1'b1;
    h_start(1'b1);
    for (int i = 0; i < 129; i++) acc(1'b1, 7'h00, i[7:0], 1'b1, q);
    h_end();
    `CHK(irq, 1'b1)
    irq_clear();
  endtask : t_overflow
  // overlap in frame mode raises underrun, random mode stays quiet
  task automatic t_viol();
    logic [7:0] q;
    i_bb.send(3'h0, 8'h00);
    peek(7'h00, 8'h00);
    `CHK(irq, 1'b0)
    h_start(1'b1);
    acc(1'b0, 7'h00, 8'h00, 1'b1, q);
    acc(1'b0, 7'h00, 8'h00, 1'b1, q);
    h_end();
    `CHK(irq, 1'b1)
    irq_clear();
    i_bb.send(3'h2, 8'h00);
    i_bb.send(3'h3, 8'h00);
    @(negedge clk);
    we = 1'b1;
    h_start(1'b1);
    acc(1'b1, 7'h00, 8'h03, 1'b1, q);
    h_end();
    `CHK(irq, 1'b1)
    irq_clear();
    i_bb.send(3'h5, 8'h00);
  endtask : t_viol
  // sleep shuts and clears the buffer; power-on needs the master clock
  task automatic t_sleep();
    logic [7:0] q;
    @(negedge clk);
    slp = 1'b1;
    @(negedge clk);
    `CHK(aok, 1'b0)
    h_start(1'b0);
    acc(1'b0, 7'h01, 8'h00, 1'b0, q);
    h_end();
    slp = 1'b0;
    peek(7'h01, 8'h00);
    pon = 1'b1;
    mok = 1'b0;
    repeat (4) @(negedge clk);
    `CHK(aok, 1'b0)
    mok = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(aok, 1'b1)
    pon = 1'b0;
  endtask : t_sleep
  initial begin
    {st, en, req, we, fm, slp, pon, prot, rtry, wack, afcs, iack} = '0;
    mok  = 1'b1;
    addr = 7'h00;
    wd   = 8'h00;
    num_errors = 0;
    n_compared = 0;
    rstn = 1'b0;
    // long enough to cover two link clock edges as well
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    t_rx();
    t_tx();
    t_fcs();
    t_retry();
    t_overwrite();
    t_overflow();
    t_viol();
    t_sleep();
    close_out();
  end
  // watchdog well beyond the fewer than a thousand cycles the run needs
  initial begin
    #500000;
    num_errors++;
    close_out();
  end
endmodule : tb_radio_frame_buffer
`default_nettype wire
